// ---- rtl/write_crc_checker.sv ----
/*
 * write-data checksum checker: samples write bursts from the pins, rebuilds
 * the code word, checks it, and commits or discards the burst to the array.
 * assumes a strobe that toggles once per beat (both edges carry data) much
 * slower than the core clock, data stable around each strobe edge, a frame
 * pin high for the whole burst, and an Avalon-MM master for the registers.
 */
`timescale 1ns/1ns

module write_crc_checker #(
   parameter int ALERT_CYCLES = crc_pkg::ALERT_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // write link pins
   input wire logic i_write_strobe,
   input wire logic i_write_frame,
   input wire logic [15:0] i_dq,
   input wire logic [1:0] i_mask_inv_n,
   // alert pin
   output logic o_alert_n,
   // array write port
   output logic o_wr_valid,
   output logic o_wr_discard,
   output logic [127:0] o_wr_data,
   output logic [15:0] o_wr_byte_en,
   // avalon-mm slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01,
      ST_CRC = 2'b10,
      ST_CHECK = 2'b11
   } state_t;

   crc_if cif ();

   // synchronised pins
   logic [19:0] pins_s;
   logic strobe_s;
   logic frame_s;
   logic [15:0] dq_s;
   logic [1:0] mi_s;
   logic strobe_d_reg;

   // burst capture
   state_t state_reg;
   state_t state_next;
   logic [3:0] beat_reg;
   logic [15:0] dq_beat_reg [8];
   logic [1:0] mi_beat_reg [8];
   logic [15:0] crc_lo_reg;
   logic [15:0] crc_hi_reg;

   // configuration and status
   logic [4:0] ctrl_reg;
   logic err_reg;
   logic discard_seen_reg;
   logic [15:0] err_count_reg;
   logic [15:0] last_calc_reg;
   logic [15:0] last_rx_reg;
   logic [3:0] alert_cnt_reg;
   logic ack_reg;

   // link pins cross into the core clock
   pin_sync #(
      .W(20)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_pins({i_write_strobe, i_write_frame, i_mask_inv_n, i_dq}),
      .o_sync(pins_s)
   );

   assign strobe_s = pins_s[19];
   assign frame_s = pins_s[18];
   assign mi_s = pins_s[17:16];
   assign dq_s = pins_s[15:0];

   // checksum trees and compare
   crc_trees u_trees (
      .bus(cif.tree)
   );

   // control decode
   logic [1:0] width;
   logic crc_en;
   logic mask_en;
   logic inv_en;
   logic lane_pin_used;
   logic beat_edge;
   assign width = ctrl_reg[crc_pkg::CTRL_WIDTH_LSB +: 2];
   assign crc_en = ctrl_reg[crc_pkg::CTRL_CRC_EN];
   assign mask_en = ctrl_reg[crc_pkg::CTRL_MASK_EN];
   assign inv_en = ctrl_reg[crc_pkg::CTRL_INV_EN];
   assign lane_pin_used = mask_en | inv_en;
   // both strobe edges mark a beat; only valid while the frame is up
   assign beat_edge = (strobe_s ^ strobe_d_reg) & frame_s;

   // code word built from raw received bits, inversion not undone
   for (genvar l = 0; l < crc_pkg::LANES; l++) begin : g_word
      for (genvar b = 0; b < crc_pkg::DATA_BEATS; b++) begin : g_beat
         for (genvar j = 0; j < 8; j++) begin : g_bit
            // x4 keeps only four data lanes, the rest read as ones
            assign cif.word[l*72 + j*8 + b] =
               (width == crc_pkg::WIDTH_X4 && j >= crc_pkg::X4_LANE_BITS) ? 1'b1 :
               dq_beat_reg[b][l*8 + j];
         end
         // mask or inversion bits only when that pin is in use
         assign cif.word[l*72 + 64 + b] =
            (lane_pin_used && width != crc_pkg::WIDTH_X4) ? mi_beat_reg[b][l] : 1'b1;
      end
   end

   // received checksum: x4 spreads it over beats 8 and 9, wider parts use beat 8
   assign cif.rx_crc = (width == crc_pkg::WIDTH_X4) ?
      {8'hff, crc_hi_reg[3:0], crc_lo_reg[3:0]} : crc_lo_reg;
   assign cif.width = width;

   logic last_data_beat;
   logic last_crc_beat;
   logic commit_early;
   logic check_now;
   assign last_data_beat = beat_edge && beat_reg == crc_pkg::BEAT_LAST_DATA;
   assign last_crc_beat = beat_edge && beat_reg == crc_pkg::BEAT_CRC_HI;
   // without masking the burst goes to the array before the
   assign commit_early = (state_reg == ST_DATA) && last_data_beat && !(crc_en && mask_en);
   assign check_now = state_reg == ST_CHECK;

   // burst sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (beat_edge) begin
               state_next = ST_DATA;
            end
         end
         ST_DATA: begin
            if (!frame_s) begin
               state_next = ST_IDLE;
            end else if (last_data_beat) begin
               state_next = crc_en ? ST_CRC : ST_IDLE;
            end
         end
         ST_CRC: begin
            if (!frame_s) begin
               state_next = ST_IDLE;
            end else if (last_crc_beat) begin
               state_next = ST_CHECK;
            end
         end
         ST_CHECK: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // state, beat count and strobe history
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= ST_IDLE;
         beat_reg <= 4'h0;
         strobe_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         strobe_d_reg <= strobe_s;
         if (state_next == ST_IDLE || state_next == ST_CHECK) begin
            beat_reg <= 4'h0;
         end else if (beat_edge) begin
            beat_reg <= beat_reg + 4'h1;
         end
      end
   end

   // beat capture; beat 9 on x8/x16 carries ones and is only taken, not checked
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int b = 0; b < crc_pkg::DATA_BEATS; b++) begin
            dq_beat_reg[b] <= 16'h0000;
            mi_beat_reg[b] <= 2'h3;
         end
         crc_lo_reg <= 16'h0000;
         crc_hi_reg <= 16'h0000;
      end else if (beat_edge && (state_reg != ST_IDLE || state_next != ST_IDLE)) begin
         // beat 7 must land even when a checksum-off burst ends on it
         if (beat_reg <= crc_pkg::BEAT_LAST_DATA) begin
            dq_beat_reg[beat_reg[2:0]] <= dq_s;
            mi_beat_reg[beat_reg[2:0]] <= mi_s;
         end else if (beat_reg == crc_pkg::BEAT_CRC_LO) begin
            crc_lo_reg <= dq_s;
         end else begin
            crc_hi_reg <= dq_s;
         end
      end
   end

   // array data: inverted bytes flipped back, masked bytes disabled
   logic [127:0] true_data;
   logic [15:0] byte_en;
   logic burst_commit;
   logic burst_discard;
   for (genvar b = 0; b < crc_pkg::DATA_BEATS; b++) begin : g_out
      for (genvar l = 0; l < crc_pkg::LANES; l++) begin : g_ln
         assign true_data[b*16 + l*8 +: 8] = dq_beat_reg[b][l*8 +: 8] ^
            {8{inv_en & ~mask_en & ~mi_beat_reg[b][l]}};
         assign byte_en[b*2 + l] = (mask_en ? mi_beat_reg[b][l] : 1'b1) &
            (l == 0 || width == crc_pkg::WIDTH_X16);
      end
   end
   // with masking the checksum gates the commit
   assign burst_commit = check_now && crc_en && mask_en && !cif.mismatch;
   assign burst_discard = check_now && crc_en && mask_en && cif.mismatch;

   // array write port; data written two cycles after the last needed beat is detected
   logic commit_late;
   logic commit_early_d_reg;
   assign commit_late = burst_commit;
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         commit_early_d_reg <= 1'b0;
         o_wr_valid <= 1'b0;
         o_wr_discard <= 1'b0;
         o_wr_data <= 128'h0;
         o_wr_byte_en <= 16'h0000;
      end else begin
         commit_early_d_reg <= commit_early;
         o_wr_valid <= commit_early_d_reg | commit_late;
         o_wr_discard <= burst_discard;
         if (commit_early_d_reg | commit_late) begin
            o_wr_data <= true_data;
            o_wr_byte_en <= byte_en;
         end
      end
   end

   // one alert per burst, only from the single check cycle
   logic alert_fire;
   assign alert_fire = check_now && cif.mismatch;
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         alert_cnt_reg <= 4'h0;
         o_alert_n <= 1'b1;
      end else begin
         if (alert_fire) begin
            alert_cnt_reg <= 4'(ALERT_CYCLES);
            o_alert_n <= 1'b0;
         end else if (alert_cnt_reg > 4'h1) begin
            alert_cnt_reg <= alert_cnt_reg - 4'h1;
         end else begin
            alert_cnt_reg <= 4'h0;
            o_alert_n <= 1'b1;
         end
      end
   end

   // register bus decode; each access waits exactly one cycle
   logic bus_req;
   logic bus_take;
   logic wr_ctrl;
   logic wr_status;
   logic err_clr;
   logic disc_clr;
   logic [31:0] rd_mux;
   assign bus_req = i_avs_read | i_avs_write;
   assign bus_take = bus_req & ack_reg;
   assign o_avs_waitrequest = bus_req & ~ack_reg;
   assign wr_ctrl = bus_take & i_avs_write & i_avs_byteenable[0] &
      (i_avs_address == crc_pkg::OFF_CTRL);
   assign wr_status = bus_take & i_avs_write & i_avs_byteenable[0] &
      (i_avs_address == crc_pkg::OFF_STATUS);
   assign err_clr = wr_status & i_avs_writedata[crc_pkg::STAT_ERR];
   assign disc_clr = wr_status & i_avs_writedata[crc_pkg::STAT_DISCARD];
   assign rd_mux =
      (i_avs_address == crc_pkg::OFF_CTRL) ? {27'h0, ctrl_reg} :
      (i_avs_address == crc_pkg::OFF_STATUS) ?
         {29'h0, discard_seen_reg, state_reg != ST_IDLE, err_reg} :
      (i_avs_address == crc_pkg::OFF_CRC) ? {last_rx_reg, last_calc_reg} :
      (i_avs_address == crc_pkg::OFF_COUNT) ? {16'h0, err_count_reg} :
      32'h0;

   // bus handshake and read data
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         ack_reg <= 1'b0;
         o_avs_readdata <= 32'h0;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
         if (i_avs_read & ~ack_reg) begin
            o_avs_readdata <= rd_mux;
         end
      end
   end

   // control register and error status; a new error beats a clear
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_reg <= crc_pkg::CTRL_RESET;
         err_reg <= 1'b0;
         discard_seen_reg <= 1'b0;
         err_count_reg <= 16'h0000;
         last_calc_reg <= 16'h0000;
         last_rx_reg <= 16'h0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= i_avs_writedata[crc_pkg::CTRL_W-1:0];
         end
         err_reg <= alert_fire | (err_reg & ~err_clr);
         discard_seen_reg <= burst_discard | (discard_seen_reg & ~disc_clr);
         if (alert_fire && err_count_reg != 16'hffff) begin
            err_count_reg <= err_count_reg + 16'h0001;
         end
         if (check_now) begin
            last_calc_reg <= cif.calc;
            last_rx_reg <= cif.rx_crc;
         end
      end
   end
endmodule : write_crc_checker

// ---- rtl/crc_pkg.sv ----
/*
 * shared constants for the write checksum checker: register map, field
 * positions, reset values, beat numbering and timing counts.
 * assumes a 10 MHz core clock; nothing else.
 */
package crc_pkg;
   // code word and lane geometry
   localparam int CW_W = 72;
   localparam int CRC_W = 8;
   localparam int LANES = 2;
   localparam int DQ_W = 16;
   localparam int DATA_BEATS = 8;
   localparam logic [3:0] BEAT_LAST_DATA = 4'h7;
   localparam logic [3:0] BEAT_CRC_LO = 4'h8;
   localparam logic [3:0] BEAT_CRC_HI = 4'h9;
   localparam int X4_LANE_BITS = 4;
   // generator x^8 + x^2 + x + 1, zero start, no final inversion
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;

   // device width selection
   typedef enum logic [1:0] {
      WIDTH_X4 = 2'b00,
      WIDTH_X8 = 2'b01,
      WIDTH_X16 = 2'b10
   } width_t;

   // register byte offsets
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_CRC = 4'h8;
   localparam logic [3:0] OFF_COUNT = 4'hc;

   // control field positions and reset value
   localparam int CTRL_WIDTH_LSB = 0;
   localparam int CTRL_CRC_EN = 2;
   localparam int CTRL_MASK_EN = 3;
   localparam int CTRL_INV_EN = 4;
   localparam int CTRL_W = 5;
   localparam logic [4:0] CTRL_RESET = 5'h04;

   // status field positions
   localparam int STAT_ERR = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_DISCARD = 2;

   // alert low time
   localparam int MCLK_KHZ = 10000;
   localparam int ALERT_NS = 600;
   localparam int ALERT_CYC = (ALERT_NS * MCLK_KHZ + 999999) / 1000000;
   localparam logic [3:0] ALERT_CYC_4 = 4'(ALERT_CYC);
endpackage : crc_pkg

// ---- rtl/crc_if.sv ----
/*
 * carrier between the burst handler and the checksum trees.
 * assumes both ends run on the same core clock.
 */
`timescale 1ns/1ns
interface crc_if;
   logic [2*crc_pkg::CW_W-1:0] word;
   logic [2*crc_pkg::CRC_W-1:0] rx_crc;
   logic [2*crc_pkg::CRC_W-1:0] calc;
   logic [1:0] width;
   logic mismatch;

   modport burst (output word, output rx_crc, output width, input calc, input mismatch);
   modport tree (input word, input rx_crc, input width, output calc, output mismatch);
endinterface : crc_if

// ---- rtl/pin_sync.sv ----
/*
 * two flip-flop synchroniser for a group of pins.
 * assumes the pins change slowly against the core clock.
 */
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // pins in, synchronised copy out
   input wire logic [W-1:0] i_pins,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_reg <= '0;
         o_sync <= '0;
      end else begin
         meta_reg <= i_pins;
         o_sync <= meta_reg;
      end
   end
endmodule : pin_sync

// ---- rtl/crc_trees.sv ----
/*
 * two identical 72-bit checksum trees, one per byte lane, and the compare.
 * assumes the code word and received checksum are held stable by the caller.
 */
`timescale 1ns/1ns
module crc_trees (
   crc_if.tree bus
);
   // serial-equivalent form, bit 71 first; unrolls to a pure xor tree
   function automatic logic [7:0] crc8(input logic [71:0] d);
      logic [7:0] c;
      logic fb;
      c = crc_pkg::CRC_INIT;
      fb = 1'b0;
      for (int i = crc_pkg::CW_W - 1; i >= 0; i--) begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? crc_pkg::CRC_POLY : 8'h00);
      end
      return c;
   endfunction : crc8

   logic [1:0] lane_bad;

   // one tree per lane, no state
   for (genvar l = 0; l < crc_pkg::LANES; l++) begin : g_lane
      assign bus.calc[l*8 +: 8] = crc8(bus.word[l*72 +: 72]);
      assign lane_bad[l] = bus.calc[l*8 +: 8] != bus.rx_crc[l*8 +: 8];
   end

   // upper tree only counts on the sixteen-bit part
   assign bus.mismatch = lane_bad[0] | (lane_bad[1] & (bus.width == crc_pkg::WIDTH_X16));
endmodule : crc_trees

// ---- tb/write_crc_checker_monitor.sv ----
/*
 * concurrent checks on the write checksum checker: alert shape, commit and
 * discard pulses, and register bus wait timing.
 * assumes it is bound to write_crc_checker and sees only its ports.
 */
`timescale 1ns/1ns
module write_crc_checker_monitor #(
   parameter int ALERT_CYCLES = 6
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rstn,
   // link and array side
   input wire logic i_write_frame,
   input wire logic o_alert_n,
   input wire logic o_wr_valid,
   input wire logic o_wr_discard,
   input wire logic [127:0] o_wr_data,
   // register bus
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rstn);

   logic [7:0] low_cnt;

   // length of the current alert pulse; a counter avoids a long repetition
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) low_cnt <= 8'h00;
      else if (o_alert_n) low_cnt <= 8'h00;
      else low_cnt <= low_cnt + 8'h01;
   end

   a_alert_len: assert property ($rose(o_alert_n) |-> low_cnt == ALERT_CYCLES)
      else $error("alert pulse length wrong");
   a_alert_once: assert property (!o_alert_n |-> low_cnt < ALERT_CYCLES)
      else $error("alert held too long");
   a_alert_framed: assert property ($fell(o_alert_n) |-> $past(i_write_frame, 2))
      else $error("alert outside a burst");
   a_discard_alert: assert property (o_wr_discard |-> $fell(o_alert_n))
      else $error("discard without alert");
   a_discard_pulse: assert property (o_wr_discard |=> !o_wr_discard && !o_wr_valid)
      else $error("discard not a single pulse");
   a_valid_pulse: assert property (o_wr_valid |=> !o_wr_valid)
      else $error("commit not a single pulse");
   a_data_hold: assert property ($changed(o_wr_data) |-> o_wr_valid || o_wr_discard)
      else $error("array data moved without commit");
   a_wait_first: assert property ((i_avs_read || i_avs_write)
      && !$past(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
      else $error("no wait cycle");
   a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest)
      else $error("wait longer than one cycle");
   a_rdata_hold: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read))
      else $error("read data moved without read");

   c_discard: cover property (o_wr_discard);
   c_alert: cover property ($rose(o_alert_n));
   c_commit: cover property (o_wr_valid);
endmodule : write_crc_checker_monitor

// ---- tb/ctrl_model.sv ----
/*
 * memory controller model: sends write bursts with appended checksum.
 * assumes a 10 MHz core clock; beats 4 cycles apart, an 800 ns strobe.
 */
`timescale 1ns/1ns
module ctrl_model (
   // core clock
   input wire logic i_mclk,
   // write link pins
   output logic o_strobe,
   output logic o_frame,
   output logic [15:0] o_dq,
   output logic [1:0] o_mask_inv_n
);
   logic [7:0] last_lo;

   // idle link; strobe stands still outside frames
   initial begin
      o_strobe = 1'b0;
      o_frame = 1'b0;
      o_dq = 16'h0000;
      o_mask_inv_n = 2'b11;
   end

   // serial form, bit 71 first, zero start, no final inversion
   function automatic logic [7:0] crc8(input logic [71:0] cw);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 71; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ (((c[7] ^ cw[i]) == 1'b1) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction : crc8

   // code word of one lane; unused places are ones
   function automatic logic [71:0] word(input logic [1:0] w, input logic [127:0] d,
         input logic [15:0] p, input logic pin_on, input int l);
      logic [71:0] cw;
      cw = '1;
      for (int b = 0; b < 8; b++) begin
         for (int j = 0; j < 8; j++) begin
            if (w != 2'b00 || j < 4) cw[j*8+b] = d[b*16+l*8+j];
         end
         if (w != 2'b00 && pin_on) cw[64+b] = p[b*2+l];
      end
      return cw;
   endfunction : word

   // only sequential bursts from column 000, no mode or readout writes
   task automatic send(input logic [1:0] w, input logic [127:0] d, input logic [15:0] p,
         input logic pin_on, input logic [15:0] flip);
      logic [7:0] hi;
      logic [15:0] beat [10];
      logic [1:0] pin [10];
      last_lo = crc8(word(w, d, p, pin_on, 0));
      hi = crc8(word(w, d, p, pin_on, 1));
      for (int b = 0; b < 8; b++) begin
         beat[b] = d[b*16 +: 16];
         pin[b] = pin_on ? p[b*2 +: 2] : 2'b11;
      end
      beat[3] = beat[3] ^ flip; // flipped after the checksum so the check must catch it
      beat[8] = (w == 2'b00) ? {12'hfff, last_lo[3:0]} : {hi, last_lo};
      beat[9] = (w == 2'b00) ? {12'hfff, last_lo[7:4]} : 16'hffff;
      pin[8] = 2'b11;
      pin[9] = 2'b11;
      @(posedge i_mclk);
      o_frame <= 1'b1;
      repeat (2) @(posedge i_mclk);
      for (int b = 0; b < 10; b++) begin
         o_dq <= beat[b];
         o_mask_inv_n <= pin[b];
         repeat (2) @(posedge i_mclk);
         o_strobe <= ~o_strobe;
         repeat (2) @(posedge i_mclk);
      end
      repeat (6) @(posedge i_mclk);
      o_frame <= 1'b0;
      o_dq <= ~beat[9]; // released lines must not keep a stale value
      o_mask_inv_n <= 2'b00;
   endtask : send
endmodule : ctrl_model

// ---- tb/testbench.sv ----
/*
 * self-checking bench: bursts through the controller model, registers over
 * avalon-mm, counts and a verdict.
 * assumes package, interface, design, monitor and model compile first.
 */
`timescale 1ns/1ns
module testbench;
   localparam logic [127:0] D1 = 128'h0123456789abcdeffedcba9876543210;
   localparam logic [127:0] L0 = {8{16'h00ff}};
   localparam logic [15:0] P = 16'h5a3c;
   logic i_mclk, i_rstn, i_avs_read, i_avs_write, o_avs_waitrequest;
   logic o_alert_n, o_wr_valid, o_wr_discard, strobe, frame, alert_q;
   logic [3:0] i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, rd;
   logic [15:0] dq, o_wr_byte_en, got_be;
   logic [1:0] mask_inv_n;
   logic [127:0] o_wr_data, got_data, exp;
   logic [15:0] flips [3] = '{16'h0002, 16'h8000, 16'h0300};
   int failures, cmp_count, n_valid, n_discard, n_alert;

   ctrl_model u_ctrl (.i_mclk(i_mclk), .o_strobe(strobe), .o_frame(frame), .o_dq(dq),
      .o_mask_inv_n(mask_inv_n));
   write_crc_checker #(.ALERT_CYCLES(6)) u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn),
      .i_write_strobe(strobe), .i_write_frame(frame), .i_dq(dq), .i_mask_inv_n(mask_inv_n),
      .o_alert_n(o_alert_n), .o_wr_valid(o_wr_valid), .o_wr_discard(o_wr_discard),
      .o_wr_data(o_wr_data), .o_wr_byte_en(o_wr_byte_en), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest));

   always #50 i_mclk = ~i_mclk;

   // tally reports at mid-cycle, clear of the launching edge
   always @(negedge i_mclk) begin
      if (o_wr_valid === 1'b1) begin
         n_valid++;
         got_data = o_wr_data;
         got_be = o_wr_byte_en;
      end
      if (o_wr_discard === 1'b1) n_discard++;
      if (o_alert_n === 1'b0 && alert_q === 1'b1) n_alert++;
      alert_q = o_alert_n;
   end

   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] ex);
      cmp_count++;
      if (seen !== ex) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, ex, seen);
      end
   endtask : check

   // one access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      logic w;
      int n;
      n = 0;
      @(posedge i_mclk);
      i_avs_read <= ~wr;
      i_avs_write <= wr;
      i_avs_address <= a;
      i_avs_writedata <= wd;
      do begin
         @(negedge i_mclk);
         w = o_avs_waitrequest;
         rd = o_avs_readdata;
         @(posedge i_mclk);
         n++;
      end while (w !== 1'b0 && n < 50);
      if (n >= 50) failures++;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask : bus

   task automatic burst(input string name, input logic [4:0] ctrl, input logic [127:0] d,
         input logic [15:0] p, input logic [15:0] flip, input int ev, ed, ea);
      int n;
      bus(1'b1, 4'h0, {27'h0, ctrl});
      n_valid = 0;
      n_discard = 0;
      n_alert = 0;
      u_ctrl.send(ctrl[1:0], d, p, ctrl[3] | ctrl[4], flip);
      n = 0;
      while (n_valid + n_discard == 0 && n < 30) begin
         @(posedge i_mclk);
         n++;
      end
      repeat (12) @(posedge i_mclk); // room for the whole alert pulse
      check({name, " commits"}, n_valid, ev);
      check({name, " discards"}, n_discard, ed);
      check({name, " alerts"}, n_alert, ea);
      $display("done: %s", name);
   endtask : burst

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   // about 800 cycles are needed; cut a hang at 20000
   initial begin
      #2000000;
      failures++;
      summarize();
   end

   initial begin
      i_mclk = 1'b0;
      i_rstn = 1'b0;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_address = 4'h0;
      i_avs_writedata = 32'h0;
      repeat (10) @(posedge i_mclk);
      i_rstn <= 1'b1;
      bus(1'b0, 4'h0, 32'h0);
      check("ctrl reset", rd, 32'(crc_pkg::CTRL_RESET));
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped read", rd, 32'h0);
      $display("done: registers");
      burst("x4 good", 5'h04, D1, 16'hffff, 16'h0, 1, 0, 0);
      bus(1'b0, 4'h8, 32'h0);
      check("x4 crc", {rd[31:16], rd[7:0]}, {8'hff, {2{u_ctrl.last_lo}}});
      burst("x4 bad", 5'h04, D1, 16'hffff, 16'h0001, 1, 0, 1);
      bus(1'b0, 4'h4, 32'h0);
      check("error flag", rd[0], 1'b1);
      bus(1'b1, 4'h4, 32'h5);
      bus(1'b0, 4'h4, 32'h0);
      check("error cleared", rd[0], 1'b0);
      burst("x4 rewrite", 5'h04, D1, 16'hffff, 16'h0, 1, 0, 0);
      burst("x8 good", 5'h05, D1, P, 16'h0, 1, 0, 0);
      check("x8 data", got_data & L0, D1 & L0);
      burst("x8 mask", 5'h0d, D1, P, 16'h0, 1, 0, 0);
      check("x8 enables", got_be & 16'h5555, P & 16'h5555);
      burst("x8 mask bad", 5'h0d, D1, P, 16'h0080, 0, 1, 1);
      bus(1'b0, 4'h4, 32'h0);
      check("discard flag", rd[2], 1'b1);
      burst("x8 invert", 5'h15, D1, P, 16'h0, 1, 0, 0);
      exp = D1;
      for (int b = 0; b < 8; b++) begin
         if (!P[b*2]) exp[b*16 +: 8] = ~D1[b*16 +: 8];
      end
      check("x8 restored", got_data & L0, exp & L0);
      burst("x8 plain", 5'h01, D1, P, 16'h0, 1, 0, 0);
      check("x8 plain data", got_data & L0, D1 & L0);
      burst("x16 good", 5'h06, ~D1, 16'hffff, 16'h0, 1, 0, 0);
      check("x16 data", got_data, ~D1);
      foreach (flips[i]) begin
         burst("x16 bad", 5'h06, ~D1, 16'hffff, flips[i], 1, 0, 1);
      end
      bus(1'b0, 4'hc, 32'h0);
      check("error count", rd[15:0], 16'h0005);
      summarize();
   end
endmodule : testbench

bind write_crc_checker write_crc_checker_monitor #(.ALERT_CYCLES(ALERT_CYCLES)) u_mon (
   .i_mclk(i_mclk), .i_rstn(i_rstn), .i_write_frame(i_write_frame), .o_alert_n(o_alert_n),
   .o_wr_valid(o_wr_valid), .o_wr_discard(o_wr_discard), .o_wr_data(o_wr_data),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest));
